// file: pkg/cfg_pkg.sv
// Constants and types for the output interface configuration registers.
// Assumes a single 50 MHz clock; serial port pins arrive synchronous to it.
package cfg_pkg;
    // Register addresses on the serial programming port
    localparam logic [11:0] ADDR_SOFT_RESET  = 12'h000;
    localparam logic [11:0] ADDR_IFACE_SEL   = 12'h007;
    localparam logic [11:0] ADDR_POWER_DOWN  = 12'h008;
    localparam logic [11:0] ADDR_FUSE_LOAD   = 12'h013;

    // Serial frame: read flag, 3 spare bits, 12 address bits, 8 data bits
    localparam int          RW_POS      = 15;
    localparam logic [4:0]  ADDR_DONE   = 5'h10;
    localparam logic [4:0]  FRAME_LAST  = 5'h17;
    localparam logic [4:0]  FRAME_BITS  = 5'h18;

    // Field positions
    localparam int RESET_BIT  = 0;
    localparam int FUSE_BIT   = 0;
    localparam int MAP_MSB    = 7;
    localparam int MAP_LSB    = 5;
    localparam int OVR_BIT    = 3;
    localparam int MODE_MSB   = 2;
    localparam int MODE_LSB   = 0;
    localparam int PD_CLKBUF  = 5;
    localparam int PD_REFAMP  = 4;
    localparam int PD_CHAN_A  = 2;
    localparam int PD_CHAN_B  = 1;
    localparam int PD_GLOBAL  = 0;
    // Power-down mask input bit order
    localparam int MASK_CLKBUF = 2;
    localparam int MASK_REFAMP = 1;
    localparam int MASK_BGAP   = 0;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        MAP_NONE      = 3'h0,
        MAP_TWO_18_14 = 3'h1,
        MAP_TWO_16    = 3'h2,
        MAP_ONE_WIRE  = 3'h3,
        MAP_HALF_WIRE = 3'h4,
        MAP_DDR       = 3'h5
    } map_code_t;

    typedef enum logic [2:0] {
        MODE_NONE      = 3'h0,
        MODE_DDR       = 3'h1,
        MODE_TWO_WIRE  = 3'h3,
        MODE_ONE_WIRE  = 3'h4,
        MODE_HALF_WIRE = 3'h5
    } mode_code_t;

    // Fuse contents; plain defaults standing in for the programmed fuses
    localparam logic [2:0] FUSE_MAP_DEFAULT  = 3'h5;
    localparam logic [2:0] FUSE_MODE_DEFAULT = 3'h1;

    // Fuse load duration
    localparam int         CLK_PERIOD_NS     = 20;
    localparam int         FUSE_LOAD_TIME_NS = 160;
    localparam int         FUSE_LOAD_CYCLES  =
        (FUSE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FUSE_LOAD_LAST    = 4'(FUSE_LOAD_CYCLES - 1);

    typedef enum logic [1:0] {
        LD_IDLE = 2'h0,
        LD_LOAD = 2'h1,
        LD_DONE = 2'h3
    } load_state_t;
endpackage

// file: pkg/cfg_fuse_if.sv
// Link between the register bank and its fuse loader.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface cfg_fuse_if;
    logic       start;
    logic       use_written;
    logic [2:0] written_map;
    logic       busy;
    logic       done;
    logic [2:0] eff_map;
    logic [2:0] fuse_mode;

    modport ctrl (
        output start, use_written, written_map,
        input  busy, done, eff_map, fuse_mode
    );
    modport loader (
        input  start, use_written, written_map,
        output busy, done, eff_map, fuse_mode
    );
endinterface

// file: src/fuse_loader.sv
// Fuse loader: fetches the interface defaults after reset and on command.
// Assumes the register bank pulses start for one cycle and holds the written map until the load ends.
`timescale 1ns/1ns
module fuse_loader (
    // Clock and reset
    input  wire logic   clk_in,
    input  wire logic   reset_in,
    input  wire logic   ce_in,
    // Register bank side
    cfg_fuse_if.loader  bus
);
    typedef struct packed {
        cfg_pkg::load_state_t fsm;
        logic [3:0]           cnt;
        logic [2:0]           eff_map;
        logic [2:0]           fuse_mode;
        logic                 busy;
        logic                 done;
    } loader_state_t;

    loader_state_t st;
    loader_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.fsm)
            cfg_pkg::LD_IDLE: begin
                if (bus.start) begin
                    next_st.fsm = cfg_pkg::LD_LOAD;
                    next_st.cnt = 4'h0;
                    next_st.busy = 1'b1;
                end
            end
            cfg_pkg::LD_LOAD: begin
                if (bus.start) begin
                    next_st.cnt = 4'h0;
                end else if (st.cnt == cfg_pkg::FUSE_LOAD_LAST) begin
                    next_st.fsm = cfg_pkg::LD_DONE;
                    next_st.eff_map = bus.use_written ? bus.written_map
                                                      : cfg_pkg::FUSE_MAP_DEFAULT;
                    next_st.fuse_mode = cfg_pkg::FUSE_MODE_DEFAULT;
                    next_st.done = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            default: begin
                // A command landing on the done cycle must not be lost
                if (bus.start) begin
                    next_st.fsm = cfg_pkg::LD_LOAD;
                    next_st.cnt = 4'h0;
                end else begin
                    next_st.fsm = cfg_pkg::LD_IDLE;
                    next_st.busy = 1'b0;
                end
            end
        endcase
    end

    // Reset starts a load, so the fuse defaults arrive with no host action
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st <= '{fsm: cfg_pkg::LD_LOAD, cnt: 4'h0, eff_map: 3'h0,
                    fuse_mode: 3'h0, busy: 1'b1, done: 1'b0};
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign bus.busy      = st.busy;
    assign bus.done      = st.done;
    assign bus.eff_map   = st.eff_map;
    assign bus.fuse_mode = st.fuse_mode;

    a_map_held: assert property (@(posedge clk_in) disable iff (reset_in)
        !(st.fsm == cfg_pkg::LD_LOAD && st.cnt == cfg_pkg::FUSE_LOAD_LAST
          && !bus.start) |=> $stable(st.eff_map))
        else $error("mapping changed outside a fuse load");

    a_auto_load: assert property (@(posedge clk_in)
        disable iff (reset_in || !ce_in || bus.start)
        st.fsm == cfg_pkg::LD_LOAD |-> ##[1:10] st.fsm == cfg_pkg::LD_DONE)
        else $error("fuse load did not finish in time");
endmodule

// file: src/output_interface_config_regs.sv
// Output interface configuration registers behind the serial port.
// Assumes serial pins synchronous to clk_in and a host that keeps its
// programming order.
// Behaviour
// - Writing 1 to reset bit restores all configuration registers.
// - Reset bit clears itself and always reads back zero.
// - Mapping codes 1..5: two-wire 18/14, two-wire 16, one, half, DDR.
// - Written mapping applies only when a fuse load command runs.
// - A fuse load discards earlier serial writes to the power-down register.
// - After reset the fuse defaults load automatically.
// - Mapping and mode fields read zero until the host writes them.
// - Override enable lets the written mode replace the fuse mode.
// - Mode codes: 1 DDR, 3 two-wire, 4 one-wire, 5 half-wire.
// - Power-down bits: channel A 2, B 1, clock buffer 5, ref amp 4.
// - Global power-down stops both channels and the blocks chosen by the mask.
`timescale 1ns/1ns
module output_interface_config_regs (
    // Clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    // Serial programming port
    input  wire logic       sclk_in,
    input  wire logic       sen_n_in,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe_out,
    // Power-down mask from the mask register
    input  wire logic [2:0] pd_mask_in,
    // Effective interface setting
    output logic [2:0]      output_bit_mapping_out,
    output logic [2:0]      iface_mode_out,
    output logic            iface_legal_out,
    output logic            fuse_busy_out,
    // Power-down controls
    output logic            chan_a_powerdown_out,
    output logic            chan_b_powerdown_out,
    output logic            sample_clock_buffer_off_out,
    output logic            reference_amp_off_out,
    output logic            bandgap_off_out
);
    typedef struct packed {
        logic        prev_sclk;
        logic [4:0]  cnt;
        logic [23:0] shift;
        logic        is_read;
        logic [7:0]  rd_sh;
        logic        sdio_o;
        logic        sdio_oe;
        logic [7:0]  output_interface_select;
        logic [7:0]  power_down_control;
        logic        written;
        logic        fuse_start;
        logic        use_written;
        logic [2:0]  written_map;
        logic [2:0]  eff_mode;
        logic        legal;
        logic [4:0]  pd_out;
    } regs_state_t;

    regs_state_t st;
    regs_state_t next_st;
    cfg_fuse_if  fuse_bus ();

    function automatic logic map_ok(input logic [2:0] code);
        map_ok = (code >= cfg_pkg::MAP_TWO_18_14) &&
                 (code <= cfg_pkg::MAP_DDR);
    endfunction

    function automatic logic mode_ok(input logic [2:0] code);
        mode_ok = (code == cfg_pkg::MODE_DDR) ||
                  ((code >= cfg_pkg::MODE_TWO_WIRE) &&
                   (code <= cfg_pkg::MODE_HALF_WIRE));
    endfunction

    function automatic logic [7:0] reg_read(input regs_state_t s,
                                            input logic [11:0] a);
        if (a == cfg_pkg::ADDR_IFACE_SEL) begin
            reg_read = s.output_interface_select;
        end else if (a == cfg_pkg::ADDR_POWER_DOWN) begin
            reg_read = s.power_down_control;
        end else begin
            // Self-clearing bits and unmapped addresses read zero
            reg_read = cfg_pkg::REG_RESET;
        end
    endfunction

    logic        active;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [23:0] next_shift_bits;
    logic        commit;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;

    assign active          = !sen_n_in;
    assign sclk_rise       = active && sclk_in && !st.prev_sclk;
    assign sclk_fall       = active && !sclk_in && st.prev_sclk;
    assign next_shift_bits = {st.shift[22:0], sdio_in};
    assign commit          = sclk_rise && st.cnt == cfg_pkg::FRAME_LAST
                             && !st.is_read;
    assign wr_addr         = next_shift_bits[19:8];
    assign wr_data         = next_shift_bits[7:0];

    always_comb begin
        next_st = st;
        next_st.prev_sclk = sclk_in;
        next_st.fuse_start = 1'b0;
        if (!active) begin
            next_st.cnt = 5'h00;
            next_st.is_read = 1'b0;
            next_st.sdio_oe = 1'b0;
        end else if (sclk_rise && st.cnt < cfg_pkg::FRAME_BITS) begin
            next_st.shift = next_shift_bits;
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt + 5'h01 == cfg_pkg::ADDR_DONE) begin
                next_st.is_read = next_shift_bits[cfg_pkg::RW_POS];
                next_st.rd_sh = reg_read(st, next_shift_bits[11:0]);
            end
        end else if (sclk_fall && st.is_read
                     && st.cnt >= cfg_pkg::ADDR_DONE
                     && st.cnt < cfg_pkg::FRAME_BITS) begin
            next_st.sdio_o = st.rd_sh[7];
            next_st.rd_sh = {st.rd_sh[6:0], 1'b0};
            next_st.sdio_oe = 1'b1;
        end
        if (fuse_bus.done) begin
            next_st.power_down_control = cfg_pkg::REG_RESET;
        end
        if (commit) begin
            if (wr_addr == cfg_pkg::ADDR_SOFT_RESET) begin
                if (wr_data[cfg_pkg::RESET_BIT]) begin
                    next_st.output_interface_select = cfg_pkg::REG_RESET;
                    next_st.power_down_control = cfg_pkg::REG_RESET;
                    next_st.written = 1'b0;
                    next_st.use_written = 1'b0;
                    next_st.fuse_start = 1'b1;
                end
            end else if (wr_addr == cfg_pkg::ADDR_IFACE_SEL) begin
                // Readback shows only what was written
                next_st.output_interface_select = wr_data;
                next_st.written = 1'b1;
            end else if (wr_addr == cfg_pkg::ADDR_POWER_DOWN) begin
                next_st.power_down_control = wr_data;
            end else if (wr_addr == cfg_pkg::ADDR_FUSE_LOAD) begin
                if (wr_data[cfg_pkg::FUSE_BIT]) begin
                    // Hand written mapping to the loader
                    next_st.fuse_start = 1'b1;
                    next_st.use_written = st.written;
                    next_st.written_map = st.output_interface_select[
                        cfg_pkg::MAP_MSB:cfg_pkg::MAP_LSB];
                end
            end
        end
        next_st.eff_mode = st.output_interface_select[cfg_pkg::OVR_BIT]
            ? st.output_interface_select[cfg_pkg::MODE_MSB:cfg_pkg::MODE_LSB]
            : fuse_bus.fuse_mode;
        next_st.legal = map_ok(fuse_bus.eff_map) && mode_ok(next_st.eff_mode);
        next_st.pd_out[4] = st.power_down_control[cfg_pkg::PD_CHAN_A]
            || st.power_down_control[cfg_pkg::PD_GLOBAL];
        next_st.pd_out[3] = st.power_down_control[cfg_pkg::PD_CHAN_B]
            || st.power_down_control[cfg_pkg::PD_GLOBAL];
        next_st.pd_out[2] = st.power_down_control[cfg_pkg::PD_CLKBUF]
            || (st.power_down_control[cfg_pkg::PD_GLOBAL]
                && pd_mask_in[cfg_pkg::MASK_CLKBUF]);
        next_st.pd_out[1] = st.power_down_control[cfg_pkg::PD_REFAMP]
            || (st.power_down_control[cfg_pkg::PD_GLOBAL]
                && pd_mask_in[cfg_pkg::MASK_REFAMP]);
        next_st.pd_out[0] = st.power_down_control[cfg_pkg::PD_GLOBAL]
            && pd_mask_in[cfg_pkg::MASK_BGAP];
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    fuse_loader u_loader (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .bus      (fuse_bus.loader)
    );

    assign fuse_bus.start       = st.fuse_start;
    assign fuse_bus.use_written = st.use_written;
    assign fuse_bus.written_map = st.written_map;

    assign sdio_out                    = st.sdio_o;
    assign sdio_oe_out                 = st.sdio_oe;
    // Loader register; changes only when a load completes
    assign output_bit_mapping_out      = fuse_bus.eff_map;
    assign iface_mode_out              = st.eff_mode;
    assign iface_legal_out             = st.legal;
    assign fuse_busy_out               = fuse_bus.busy;
    assign chan_a_powerdown_out        = st.pd_out[4];
    assign chan_b_powerdown_out        = st.pd_out[3];
    assign sample_clock_buffer_off_out = st.pd_out[2];
    assign reference_amp_off_out       = st.pd_out[1];
    assign bandgap_off_out             = st.pd_out[0];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence soft_reset_wr;
        ce_in && commit && wr_addr == cfg_pkg::ADDR_SOFT_RESET
            && wr_data[cfg_pkg::RESET_BIT];
    endsequence
    sequence fuse_wr;
        ce_in && commit && wr_addr == cfg_pkg::ADDR_FUSE_LOAD
            && wr_data[cfg_pkg::FUSE_BIT];
    endsequence

    a_soft_reset_regs: assert property (soft_reset_wr |=>
        st.output_interface_select == 8'h00
        && st.power_down_control == 8'h00 && !st.written && st.fuse_start)
        else $error("soft reset left registers set");
    a_reset_bit_zero: assert property (ce_in && sclk_rise
        && st.cnt == 5'h0F && next_shift_bits[11:0] == 12'h000
        |=> st.rd_sh == 8'h00)
        else $error("reset bit read back nonzero");
    a_fuse_handoff: assert property (fuse_wr |=> st.fuse_start
        && st.written_map == $past(st.output_interface_select[7:5])
        && st.use_written == $past(st.written))
        else $error("fuse load did not take the written mapping");
    a_fuse_discard: assert property (ce_in && fuse_bus.done
        && !commit |=> st.power_down_control == 8'h00)
        else $error("fuse load kept power-down writes");
    a_readback_zero: assert property (!st.written
        |-> st.output_interface_select == 8'h00)
        else $error("unwritten select register read nonzero");
    a_override_mode: assert property (ce_in
        && st.output_interface_select[3]
        |=> iface_mode_out == $past(st.output_interface_select[2:0]))
        else $error("override did not apply written mode");
    a_chan_a_off: assert property (ce_in
        && st.power_down_control[2] |=> chan_a_powerdown_out)
        else $error("channel A not powered down");
    a_global_mask: assert property (ce_in && st.power_down_control[0]
        && pd_mask_in[1] |=> reference_amp_off_out && chan_b_powerdown_out)
        else $error("global power-down ignored the mask");
endmodule

// file: verification/spi_host_model.sv
// Host controller model driving the serial programming port.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ns
module spi_host_model (
    // Clock
    input  wire logic clk_in,
    // Device side of the data pin
    input  wire logic sdio_dev_in,
    input  wire logic sdio_oe_in,
    // Serial port
    output logic      sclk_out,
    output logic      sen_n_out,
    output logic      sdio_line_out
);
    logic host_bit;
    logic host_en;

    // Released pin shows the inverse, never a stale copy
    assign sdio_line_out = sdio_oe_in ? sdio_dev_in
                         : (host_en ? host_bit : ~host_bit);

    initial begin
        sclk_out  = 1'b0;
        sen_n_out = 1'b1;
        host_bit  = 1'b0;
        host_en   = 1'b0;
    end

    // Phases of three cycles keep the two-cycle minimum with margin
    task automatic xfer(input logic rd, input logic [11:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [23:0] frame;
        frame = {rd, 3'h0, addr, wdata};
        rdata = 8'h00;
        @(posedge clk_in);
        sen_n_out <= 1'b0;
        host_en   <= 1'b1;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_in);
            host_bit <= frame[i];
            if (rd && i < 8) begin
                host_en <= 1'b0;
            end
            repeat (2) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            if (rd && i < 8) begin
                rdata[i] = sdio_line_out;
            end
            sclk_out <= 1'b0;
        end
        repeat (3) @(posedge clk_in);
        sen_n_out <= 1'b1;
        host_en   <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the output interface configuration registers.
// Assumes the host model and the package constants are compiled first.
`timescale 1ns/1ns
module tb_top;
    logic       clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       ce_in = 1'b1;
    logic [2:0] pd_mask_in = 3'h0;
    logic       sclk, sen_n, sdio_line, sdio_out, sdio_oe_out;
    logic [2:0] map_out, mode_out;
    logic       legal_out, busy_out;
    logic       pd_a, pd_b, pd_clk, pd_ref, pd_bg;
    int         errors = 0;
    int         total_checks = 0;
    logic [7:0] rdat, wdat;
    logic [7:0] pd;
    logic [2:0] msk, mode, prev_map, exp_mode;
    logic       ovr;

    always #10 clk_in = ~clk_in;

    output_interface_config_regs dut (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
        .sclk_in(sclk), .sen_n_in(sen_n), .sdio_in(sdio_line),
        .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
        .pd_mask_in(pd_mask_in),
        .output_bit_mapping_out(map_out), .iface_mode_out(mode_out),
        .iface_legal_out(legal_out), .fuse_busy_out(busy_out),
        .chan_a_powerdown_out(pd_a), .chan_b_powerdown_out(pd_b),
        .sample_clock_buffer_off_out(pd_clk),
        .reference_amp_off_out(pd_ref), .bandgap_off_out(pd_bg));

    spi_host_model host (
        .clk_in(clk_in), .sdio_dev_in(sdio_out), .sdio_oe_in(sdio_oe_out),
        .sclk_out(sclk), .sen_n_out(sen_n), .sdio_line_out(sdio_line));

    function automatic logic exp_legal(logic [2:0] m, logic [2:0] md);
        return (m >= 3'h1 && m <= 3'h5) &&
               (md == 3'h1 || (md >= 3'h3 && md <= 3'h5));
    endfunction

    // Order: clock buffer, ref amp, channel A, channel B, bandgap
    function automatic logic [4:0] exp_pd(logic [7:0] p, logic [2:0] m);
        logic g;
        g = p[cfg_pkg::PD_GLOBAL];
        return {p[cfg_pkg::PD_CLKBUF] | (g & m[cfg_pkg::MASK_CLKBUF]),
                p[cfg_pkg::PD_REFAMP] | (g & m[cfg_pkg::MASK_REFAMP]),
                p[cfg_pkg::PD_CHAN_A] | g, p[cfg_pkg::PD_CHAN_B] | g,
                g & m[cfg_pkg::MASK_BGAP]};
    endfunction

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, unused);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic rd(logic [11:0] a, output logic [7:0] d);
        host.xfer(1'b1, a, 8'h00, d);
        check("sdio_oe_idle", 8'h00, {7'h0, sdio_oe_out});
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        repeat (2) @(posedge clk_in);
        while (busy_out !== 1'b0 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 50) begin
            errors++;
            $display("ERROR fuse_busy expected 0 seen %b", busy_out);
        end
        repeat (2) @(posedge clk_in);
    endtask

    task automatic fuse_load;
        wr(cfg_pkg::ADDR_FUSE_LOAD, 8'h01);
        wait_idle();
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hD5C3));
        repeat (4) @(posedge clk_in);
        check("busy_in_reset", 8'h01, {7'h0, busy_out});
        reset_in <= 1'b0;
        wait_idle();
        check("map_after_reset", 8'(cfg_pkg::FUSE_MAP_DEFAULT),
              8'(map_out));
        check("mode_after_reset", 8'(cfg_pkg::FUSE_MODE_DEFAULT),
              8'(mode_out));
        rd(cfg_pkg::ADDR_IFACE_SEL, rdat);
        check("iface_sel_read", 8'h00, rdat);
        rd(cfg_pkg::ADDR_POWER_DOWN, rdat);
        check("power_down_read", cfg_pkg::REG_RESET, rdat);
        prev_map = cfg_pkg::FUSE_MAP_DEFAULT;
        // A select register write opens and a fuse load closes each programming pass
        for (int m = 1; m <= 5; m++) begin
            mode = 3'($urandom);
            ovr  = 1'($urandom);
            wdat = {3'(m), 1'b0, ovr, mode};
            wr(cfg_pkg::ADDR_IFACE_SEL, wdat);
            check("map_before_load", 8'(prev_map), 8'(map_out));
            exp_mode = ovr ? mode : cfg_pkg::FUSE_MODE_DEFAULT;
            check("mode_override", 8'(exp_mode), 8'(mode_out));
            rd(cfg_pkg::ADDR_IFACE_SEL, rdat);
            check("iface_sel_read", wdat, rdat);
            fuse_load();
            check("map_after_load", 8'(m), 8'(map_out));
            check("legal", 8'(exp_legal(3'(m), exp_mode)),
                  8'(legal_out));
            prev_map = 3'(m);
        end
        for (int md = 0; md < 8; md++) begin
            wr(cfg_pkg::ADDR_IFACE_SEL, {5'h11, 3'(md)});
            check("mode_code", 8'(md), 8'(mode_out));
            check("mode_legal", 8'(exp_legal(prev_map, 3'(md))),
                  8'(legal_out));
        end
        for (int k = 0; k < 10; k++) begin
            pd  = (k < 2) ? 8'h01 : (8'($urandom) & 8'h37);
            msk = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'($urandom);
            @(posedge clk_in);
            pd_mask_in <= msk;
            wr(cfg_pkg::ADDR_POWER_DOWN, pd);
            check("pd_outputs", 8'(exp_pd(pd, msk)),
                  8'({pd_clk, pd_ref, pd_a, pd_b, pd_bg}));
            rd(cfg_pkg::ADDR_POWER_DOWN, rdat);
            check("pd_read", pd, rdat);
        end
        wr(cfg_pkg::ADDR_POWER_DOWN, 8'h37);
        fuse_load();
        rd(cfg_pkg::ADDR_POWER_DOWN, rdat);
        check("pd_after_load", 8'h00, rdat);
        check("pd_out_after_load", 8'h00,
              8'({pd_clk, pd_ref, pd_a, pd_b, pd_bg}));
        wr(cfg_pkg::ADDR_POWER_DOWN, 8'h36);
        wr(cfg_pkg::ADDR_IFACE_SEL, 8'h6B);
        wr(cfg_pkg::ADDR_SOFT_RESET, 8'h01);
        wait_idle();
        rd(cfg_pkg::ADDR_SOFT_RESET, rdat);
        check("reset_bit", 8'h00, rdat);
        rd(cfg_pkg::ADDR_IFACE_SEL, rdat);
        check("iface_sel_reset", 8'h00, rdat);
        rd(cfg_pkg::ADDR_POWER_DOWN, rdat);
        check("pd_reset", 8'h00, rdat);
        check("map_soft_reset", 8'(cfg_pkg::FUSE_MAP_DEFAULT),
              8'(map_out));
        check("mode_soft_reset", 8'(cfg_pkg::FUSE_MODE_DEFAULT),
              8'(mode_out));
        // Enable low freezes all state, so a frame sent then is lost
        ce_in <= 1'b0;
        wr(cfg_pkg::ADDR_POWER_DOWN, 8'h24);
        ce_in <= 1'b1;
        rd(cfg_pkg::ADDR_POWER_DOWN, rdat);
        check("pd_frozen", 8'h00, rdat);
        check("pd_out_frozen", 8'h00,
              8'({pd_clk, pd_ref, pd_a, pd_b, pd_bg}));
        wr(12'h0FF, 8'h55);
        rd(12'h0FF, rdat);
        check("unmapped_read", 8'h00, rdat);
        rd(cfg_pkg::ADDR_FUSE_LOAD, rdat);
        check("fuse_reg_read", 8'h00, rdat);
        print_verdict();
    end
endmodule
